/* File: verilog/acpc_pkg.sv */
// Constants, register map and encodings of the audio clock and PLL configuration block.
package acpc_pkg;

  localparam int ACPC_DATA_W = 32;
  localparam int ACPC_ADDR_W = 12;

  localparam logic [11:0] ACPC_OFF_CLOCK_CTRL = 12'h000;
  localparam logic [11:0] ACPC_OFF_PLL_CTRL = 12'h004;
  localparam logic [11:0] ACPC_OFF_STATUS = 12'h008;

  localparam int ACPC_CTL_PLL_SEL_BIT = 0;
  localparam int ACPC_CTL_RATIO_LSB = 1;
  localparam int ACPC_CTL_RATE_LSB = 4;
  localparam int ACPC_CTL_HALVE_BIT = 8;
  localparam int ACPC_CTL_RUN_BIT = 12;
  localparam int ACPC_PLL_FRAC_LSB = 0;
  localparam int ACPC_PLL_INT_LSB = 16;
  localparam int ACPC_STS_RELEASED_BIT = 0;
  localparam int ACPC_STS_PLL_ON_BIT = 1;
  localparam int ACPC_STS_RUN_BIT = 2;

  localparam int ACPC_FRAC_W = 11;
  localparam int ACPC_INT_W = 5;

  localparam logic [1:0] ACPC_RATIO_256 = 2'h0;
  localparam logic [1:0] ACPC_RATIO_384 = 2'h1;
  localparam logic [1:0] ACPC_RATIO_512 = 2'h2;
  localparam logic [9:0] ACPC_FRAME_256 = 10'h100;
  localparam logic [9:0] ACPC_FRAME_384 = 10'h180;
  localparam logic [9:0] ACPC_FRAME_512 = 10'h200;

  // Codes 0 to 9: 8, 11.025, 12, 16, 22.05, 24, 32, 44.1, 48 and 96 kHz.
  localparam logic [3:0] ACPC_RATE_8K = 4'h0;
  localparam logic [3:0] ACPC_RATE_48K = 4'h8;
  localparam logic [3:0] ACPC_RATE_96K = 4'h9;

  localparam logic [4:0] ACPC_INT_RST = 5'h10;
  localparam logic [10:0] ACPC_FRAC_RST = 11'h312;

  localparam int ACPC_RESET_MCLK_CYCLES = 8;
  localparam int ACPC_RESET_TIME_NS = 1000;
  localparam int ACPC_MCLK_MIN_KHZ = 8000;
  localparam int ACPC_RESET_TIME_MCLK = ACPC_RESET_TIME_NS * ACPC_MCLK_MIN_KHZ / 1000000;

  typedef enum logic [1:0] {
    ACPC_RST_HOLD = 2'b00,
    ACPC_RST_COUNT = 2'b01,
    ACPC_RST_DONE = 2'b10
  } acpc_rst_state_t;

endpackage

/* File: verilog/acpc_top.sv */
// Clock and reset control for the audio codec: power-up reset, clock mode, PLL setup and APB registers.
//
// Summary of operation
// - Internal reset releases only after eight master clock edges with all supplies up.
// - Synchronous mode accepts master clock at 256, 384 or 512 times sample rate.
// - Ten sample rates from 8 kHz to 96 kHz are supported.
// - At 96 kHz only the 256 ratio is allowed.
// - Synchronous mode keeps the PLL switched off to save power.
// - PLL mode accepts any master clock from 8.0 to 27 MHz.
// - PLL mode derives internal and serial audio clocks from the PLL output.
// - The reset delay equals about 1.0 us at an 8.0 MHz master clock.
`timescale 1ns/1ps
`default_nettype none

module acpc_top
  import acpc_pkg::*;
#(
  parameter int RESET_EDGES = ACPC_RESET_MCLK_CYCLES
)
(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic SUPPLY_GOOD,
  input wire logic SYSTEM_MASTER_CLOCK,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ACPC_ADDR_W-1:0] PADDR,
  input wire logic [ACPC_DATA_W-1:0] PWDATA,
  output logic [ACPC_DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic INTERNAL_RESET_N,
  output logic PLL_ENABLE,
  output logic AUDIO_CLOCK_FROM_PLL,
  output logic PLL_REF_CLOCK,
  output logic INPUT_CLOCK_HALVE,
  output logic [ACPC_INT_W-1:0] PLL_INTEGER_DIVISOR,
  output logic [ACPC_FRAC_W-1:0] PLL_FRACTION_DIVISOR,
  output logic [1:0] MASTER_RATIO,
  output logic [3:0] SAMPLE_RATE,
  output logic AUDIO_RUN,
  output logic FRAME_TICK
);

  if (RESET_EDGES < 1 || RESET_EDGES > 15 || ACPC_RESET_TIME_MCLK != ACPC_RESET_MCLK_CYCLES)
  begin : g_bad_edges
    $error("acpc_top: reset edge count out of range");
  end

  typedef struct packed {
    acpc_rst_state_t rst_state;
    logic [3:0] rst_cnt;
    logic released;
    logic mclk_prev;
    logic pll_sel;
    logic [1:0] ratio;
    logic [3:0] rate;
    logic halve;
    logic run;
    logic [ACPC_INT_W-1:0] int_div;
    logic [ACPC_FRAC_W-1:0] frac_div;
    logic pll_on;
    logic ref_clk;
    logic [9:0] frame_cnt;
    logic frame_tick;
    logic [ACPC_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } acpc_state_t;

  acpc_state_t s_q;
  acpc_state_t s_d;

  logic mclk_rise;
  logic access;
  logic commit;
  logic ctl_bad;
  logic pll_bad;
  logic [1:0] w_ratio;
  logic [3:0] w_rate;
  logic [9:0] frame_len;

  assign mclk_rise = SYSTEM_MASTER_CLOCK & ~s_q.mclk_prev;
  assign access = PSEL & PENABLE;
  assign commit = access & s_q.pready;
  assign w_ratio = PWDATA[ACPC_CTL_RATIO_LSB +: 2];
  assign w_rate = PWDATA[ACPC_CTL_RATE_LSB +: 4];

  always_comb
  begin
    case (s_q.ratio)
      ACPC_RATIO_384: frame_len = ACPC_FRAME_384;
      ACPC_RATIO_512: frame_len = ACPC_FRAME_512;
      default: frame_len = ACPC_FRAME_256;
    endcase
  end

  assign ctl_bad = (w_ratio != ACPC_RATIO_256 && w_ratio != ACPC_RATIO_384 && w_ratio != ACPC_RATIO_512) ||
    w_rate > ACPC_RATE_96K || (w_rate == ACPC_RATE_96K && w_ratio != ACPC_RATIO_256) ||
    (s_q.run && (PWDATA[ACPC_CTL_PLL_SEL_BIT] != s_q.pll_sel || w_ratio != s_q.ratio ||
    w_rate != s_q.rate || PWDATA[ACPC_CTL_HALVE_BIT] != s_q.halve));
  assign pll_bad = s_q.run;

  always_comb
  begin
    s_d = s_q;
    s_d.mclk_prev = SYSTEM_MASTER_CLOCK;
    s_d.frame_tick = 1'b0;

    case (s_q.rst_state)
      ACPC_RST_HOLD:
      begin
        s_d.rst_cnt = 4'h0;
        s_d.released = 1'b0;
        if (SUPPLY_GOOD)
        begin
          s_d.rst_state = ACPC_RST_COUNT;
        end
      end
      ACPC_RST_COUNT:
      begin
        if (!SUPPLY_GOOD)
        begin
          s_d.rst_state = ACPC_RST_HOLD;
        end
        else if (mclk_rise)
        begin
          if (s_q.rst_cnt == 4'(RESET_EDGES - 1))
          begin
            s_d.rst_state = ACPC_RST_DONE;
            s_d.released = 1'b1;
          end
          else
          begin
            s_d.rst_cnt = s_q.rst_cnt + 4'h1;
          end
        end
      end
      ACPC_RST_DONE:
      begin
        if (!SUPPLY_GOOD)
        begin
          s_d.rst_state = ACPC_RST_HOLD;
          s_d.released = 1'b0;
        end
      end
      default:
      begin
        s_d.rst_state = ACPC_RST_HOLD;
        s_d.released = 1'b0;
      end
    endcase

    // One wait state: ready rises in the second access cycle, the transfer ends on the next edge.
    s_d.pready = access & ~s_q.pready;
    s_d.pslverr = 1'b0;
    if (access && !s_q.pready)
    begin
      s_d.prdata = '0;
      if (!s_q.released)
      begin
        s_d.pslverr = 1'b1;
      end
      else
      begin
        case (PADDR)
          ACPC_OFF_CLOCK_CTRL:
          begin
            s_d.prdata[ACPC_CTL_PLL_SEL_BIT] = s_q.pll_sel;
            s_d.prdata[ACPC_CTL_RATIO_LSB +: 2] = s_q.ratio;
            s_d.prdata[ACPC_CTL_RATE_LSB +: 4] = s_q.rate;
            s_d.prdata[ACPC_CTL_HALVE_BIT] = s_q.halve;
            s_d.prdata[ACPC_CTL_RUN_BIT] = s_q.run;
            s_d.pslverr = PWRITE & ctl_bad;
          end
          ACPC_OFF_PLL_CTRL:
          begin
            s_d.prdata[ACPC_PLL_FRAC_LSB +: ACPC_FRAC_W] = s_q.frac_div;
            s_d.prdata[ACPC_PLL_INT_LSB +: ACPC_INT_W] = s_q.int_div;
            s_d.pslverr = PWRITE & pll_bad;
          end
          ACPC_OFF_STATUS:
          begin
            s_d.prdata[ACPC_STS_RELEASED_BIT] = s_q.released;
            s_d.prdata[ACPC_STS_PLL_ON_BIT] = s_q.pll_on;
            s_d.prdata[ACPC_STS_RUN_BIT] = s_q.run;
          end
          default:
          begin
            s_d.pslverr = 1'b1;
          end
        endcase
      end
    end

    // A refused write leaves every field as it was.
    if (commit && PWRITE && !s_q.pslverr)
    begin
      if (PADDR == ACPC_OFF_CLOCK_CTRL)
      begin
        s_d.pll_sel = PWDATA[ACPC_CTL_PLL_SEL_BIT];
        s_d.ratio = w_ratio;
        s_d.rate = w_rate;
        s_d.halve = PWDATA[ACPC_CTL_HALVE_BIT];
        s_d.run = PWDATA[ACPC_CTL_RUN_BIT];
      end
      if (PADDR == ACPC_OFF_PLL_CTRL)
      begin
        s_d.frac_div = PWDATA[ACPC_PLL_FRAC_LSB +: ACPC_FRAC_W];
        s_d.int_div = PWDATA[ACPC_PLL_INT_LSB +: ACPC_INT_W];
      end
    end

    s_d.pll_on = s_d.pll_sel & s_d.released;

    if (!s_q.pll_on)
    begin
      s_d.ref_clk = 1'b0;
    end
    else if (s_q.halve)
    begin
      s_d.ref_clk = mclk_rise ? ~s_q.ref_clk : s_q.ref_clk;
    end
    else
    begin
      s_d.ref_clk = SYSTEM_MASTER_CLOCK;
    end

    // Frame rate from master clock ratio
    if (!s_q.run || s_q.pll_sel || !s_q.released)
    begin
      s_d.frame_cnt = 10'h000;
    end
    else if (mclk_rise)
    begin
      if (s_q.frame_cnt == frame_len - 10'h001)
      begin
        s_d.frame_cnt = 10'h000;
        s_d.frame_tick = 1'b1;
      end
      else
      begin
        s_d.frame_cnt = s_q.frame_cnt + 10'h001;
      end
    end

    // Internal reset clears the configuration, as a fresh power-up would.
    if (!s_d.released)
    begin
      s_d.pll_sel = 1'b0;
      s_d.ratio = ACPC_RATIO_256;
      s_d.rate = ACPC_RATE_48K;
      s_d.halve = 1'b0;
      s_d.run = 1'b0;
      s_d.int_div = ACPC_INT_RST;
      s_d.frac_div = ACPC_FRAC_RST;
      s_d.pll_on = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s_q <= '{rst_state: ACPC_RST_HOLD, ratio: ACPC_RATIO_256, rate: ACPC_RATE_48K,
               int_div: ACPC_INT_RST, frac_div: ACPC_FRAC_RST, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign INTERNAL_RESET_N = s_q.released;
  assign PLL_ENABLE = s_q.pll_on;
  assign AUDIO_CLOCK_FROM_PLL = s_q.pll_on;
  assign PLL_REF_CLOCK = s_q.ref_clk;
  assign INPUT_CLOCK_HALVE = s_q.halve;
  assign PLL_INTEGER_DIVISOR = s_q.int_div;
  assign PLL_FRACTION_DIVISOR = s_q.frac_div;
  assign MASTER_RATIO = s_q.ratio;
  assign SAMPLE_RATE = s_q.rate;
  assign AUDIO_RUN = s_q.run;
  assign FRAME_TICK = s_q.frame_tick;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);

  chk_release_count: assert property ($rose(INTERNAL_RESET_N) |-> $past(s_q.rst_cnt) == 4'(RESET_EDGES - 1))
    else $error("reset released after wrong edge count");
  chk_supply_loss: assert property (!SUPPLY_GOOD |=> !INTERNAL_RESET_N)
    else $error("reset not asserted on supply loss");
  chk_early_refuse: assert property (PREADY && !INTERNAL_RESET_N |-> PSLVERR)
    else $error("access before reset release not refused");
  chk_rate_legal: assert property (SAMPLE_RATE <= ACPC_RATE_96K && MASTER_RATIO != 2'h3)
    else $error("illegal rate or ratio stored");
  chk_96k_ratio: assert property (SAMPLE_RATE == ACPC_RATE_96K |-> MASTER_RATIO == ACPC_RATIO_256)
    else $error("96 kHz stored with ratio other than 256");
  chk_pll_off_sync: assert property (!s_q.pll_sel |-> !PLL_ENABLE && !AUDIO_CLOCK_FROM_PLL)
    else $error("PLL enabled in synchronous mode");
  chk_halve_toggle: assert property (PLL_ENABLE && INPUT_CLOCK_HALVE && $past(PLL_ENABLE) && mclk_rise
    |=> PLL_REF_CLOCK != $past(PLL_REF_CLOCK))
    else $error("halved reference did not toggle");
  chk_frozen_div: assert property (AUDIO_RUN ##1 AUDIO_RUN |-> $stable(PLL_INTEGER_DIVISOR) &&
    $stable(PLL_FRACTION_DIVISOR) && $stable(SAMPLE_RATE))
    else $error("configuration changed while running");
  chk_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("ready not one wait state");
  chk_frame_gap: assert property (FRAME_TICK |=> !FRAME_TICK [*8])
    else $error("frame ticks too close");

endmodule

`default_nettype wire

/* File: tb/acpc_mclk_src.sv */
// Master clock source model that feeds the block's master clock pin.
`timescale 1ns/1ps
`default_nettype none

module acpc_mclk_src
#(
  parameter int HALF = 2
)
(
  input wire logic clk,
  input wire logic run,
  input wire logic fast,
  output logic mclk
);
  int cnt = 0;
  logic mclk_q = 1'b0;

  assign mclk = mclk_q;

  // Source stands low when stopped; fast toggles on every edge for a 20 MHz clock.
  always @(posedge clk)
  begin
    if (!run)
    begin
      mclk_q <= 1'b0;
      cnt <= 0;
    end
    else if (fast || cnt == HALF - 1)
    begin
      mclk_q <= ~mclk_q;
      cnt <= 0;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

`default_nettype wire

/* File: tb/tb_audio_clock_pll_config.sv */
// Self-checking testbench of the audio clock and PLL configuration block.
`timescale 1ns/1ps
`default_nettype none

module tb_audio_clock_pll_config;
  import acpc_pkg::*;
  // Master clock is four bench cycles, 10 MHz, so the halve bit stays clear.
  localparam int MCLK_KHZ = 10000;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic supply_good = 1'b0;
  logic mclk_run = 1'b0;
  logic mclk_fast = 1'b0;
  logic mclk;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, irst_n, pll_en, from_pll, ref_clk, halve, run, tick;
  logic [4:0] int_div;
  logic [10:0] frac_div;
  logic [1:0] ratio;
  logic [3:0] rate;
  logic mprev = 1'b0;
  logic [31:0] rd;
  logic err;
  int rises = 0;
  int failures = 0;
  int checked = 0;

  initial
  begin
    forever #12.5 clock = ~clock;
  end

  acpc_mclk_src #(.HALF(2)) src (.clk(clock), .run(mclk_run), .fast(mclk_fast), .mclk(mclk));

  acpc_top #(.RESET_EDGES(ACPC_RESET_MCLK_CYCLES)) uut (.CLOCK(clock), .ARST_N(arst_n),
    .SUPPLY_GOOD(supply_good), .SYSTEM_MASTER_CLOCK(mclk), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .INTERNAL_RESET_N(irst_n), .PLL_ENABLE(pll_en), .AUDIO_CLOCK_FROM_PLL(from_pll),
    .PLL_REF_CLOCK(ref_clk), .INPUT_CLOCK_HALVE(halve), .PLL_INTEGER_DIVISOR(int_div),
    .PLL_FRACTION_DIVISOR(frac_div), .MASTER_RATIO(ratio), .SAMPLE_RATE(rate), .AUDIO_RUN(run),
    .FRAME_TICK(tick));

  always @(posedge clock)
  begin
    mprev <= mclk;
    if (mclk && !mprev)
      rises <= rises + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // The extra edge at the end lets the stored fields reach the outputs.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clock);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
      failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic t_reset;
    chk({irst_n, pll_en, run, halve}, 4'h0);
    chk({int_div, frac_div}, {ACPC_INT_RST, ACPC_FRAC_RST});
    chk({ratio, rate}, {ACPC_RATIO_256, ACPC_RATE_48K});
  endtask

  task automatic t_release;
    int n;
    int base;
    supply_good <= 1'b1;
    repeat (4) @(posedge clock);
    apb(1'b0, ACPC_OFF_STATUS, 32'h00000000);
    chk(err, 1'b1);
    mclk_run <= 1'b1;
    base = rises;
    for (n = 0; n < 200 && irst_n !== 1'b1; n++)
      @(posedge clock);
    chk(rises - base, ACPC_RESET_MCLK_CYCLES);
    apb(1'b0, ACPC_OFF_STATUS, 32'h00000000);
    chk({err, rd[2:0]}, 4'h1);
  endtask

  task automatic t_sync;
    int r;
    int f;
    logic e;
    for (r = 0; r < 4; r++)
      for (f = 0; f < 11; f++)
      begin
        e = (r == 3) || (f > 9) || (f == 9 && r != 0);
        apb(1'b1, ACPC_OFF_CLOCK_CTRL, {24'h000000, f[3:0], 1'b0, r[1:0], 1'b0});
        chk(err, e);
        if (!e)
        begin
          chk({ratio, rate}, {r[1:0], f[3:0]});
          chk({pll_en, ref_clk}, 2'h0);
        end
      end
  endtask

  task automatic t_tick;
    int n;
    int base;
    apb(1'b1, ACPC_OFF_CLOCK_CTRL, 32'h00001082);
    chk({err, run}, 2'h1);
    for (n = 0; n < 3000 && tick !== 1'b1; n++)
      @(posedge clock);
    base = rises;
    @(posedge clock);
    for (n = 0; n < 3000 && tick !== 1'b1; n++)
      @(posedge clock);
    chk(rises - base, 384);
    // The refused divisors differ from the reset values, so a store would show.
    apb(1'b1, ACPC_OFF_PLL_CTRL, 32'h00130549);
    chk(err, 1'b1);
    chk({int_div, frac_div}, {ACPC_INT_RST, ACPC_FRAC_RST});
    apb(1'b1, ACPC_OFF_CLOCK_CTRL, 32'h00001072);
    chk(err, 1'b1);
    chk(rate, ACPC_RATE_48K);
    apb(1'b0, 12'h00C, 32'h00000000);
    chk(err, 1'b1);
    chk(rd, 32'h00000000);
    apb(1'b1, ACPC_OFF_CLOCK_CTRL, 32'h00000082);
    chk({err, run}, 2'h0);
  endtask

  task automatic t_pll;
    int iv;
    int fv;
    int bad;
    logic [31:0] w;
    iv = 196608 / MCLK_KHZ;
    fv = 196608 * 2048 / MCLK_KHZ - iv * 2048;
    w = {11'h000, iv[4:0], 5'h00, fv[10:0]};
    apb(1'b1, ACPC_OFF_PLL_CTRL, w);
    chk({err, int_div, frac_div}, {1'b0, iv[4:0], fv[10:0]});
    apb(1'b0, ACPC_OFF_PLL_CTRL, 32'h00000000);
    chk(rd, w);
    // Halve stays clear below 17 MHz.
    apb(1'b1, ACPC_OFF_CLOCK_CTRL, 32'h00000081);
    chk({err, pll_en, from_pll, halve}, 4'h6);
    bad = 0;
    repeat (40)
    begin
      @(posedge clock);
      if (ref_clk !== mprev)
        bad++;
    end
    chk(bad, 0);
    apb(1'b0, ACPC_OFF_STATUS, 32'h00000000);
    chk(rd[2:0], 3'h3);
  endtask

  // A 20 MHz master halved gives 10 MHz, so the divisors written for 10 MHz stay right.
  task automatic t_halve;
    int tog;
    int base;
    logic last;
    // Halve is set only with the master clock at 20 MHz.
    mclk_fast <= 1'b1;
    repeat (4) @(posedge clock);
    apb(1'b1, ACPC_OFF_CLOCK_CTRL, 32'h00000181);
    chk({err, pll_en, halve}, 3'h3);
    tog = 0;
    last = ref_clk;
    base = rises;
    repeat (40)
    begin
      @(posedge clock);
      if (ref_clk !== last)
        tog++;
      last = ref_clk;
    end
    chk(tog, rises - base);
    chk(tog, 20);
  endtask

  // Supply loss with the PLL on: internal reset returns, configuration is cleared, release counts again.
  task automatic t_supply;
    int n;
    int base;
    supply_good <= 1'b0;
    mclk_run <= 1'b0;
    repeat (2) @(posedge clock);
    chk({irst_n, pll_en, halve, run}, 4'h0);
    chk({int_div, frac_div}, {ACPC_INT_RST, ACPC_FRAC_RST});
    supply_good <= 1'b1;
    mclk_run <= 1'b1;
    base = rises;
    for (n = 0; n < 200 && irst_n !== 1'b1; n++)
      @(posedge clock);
    chk(rises - base, ACPC_RESET_MCLK_CYCLES);
    apb(1'b0, ACPC_OFF_CLOCK_CTRL, 32'h00000000);
    chk(err, 1'b0);
    chk(rd, {24'h000000, ACPC_RATE_48K, 4'h0});
  endtask

  task automatic end_of_test;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clock);
    failures++;
    end_of_test();
  end

  initial
  begin
    repeat (16) @(posedge clock);
    t_reset();
    arst_n <= 1'b1;
    t_release();
    t_sync();
    t_tick();
    t_pll();
    t_halve();
    t_supply();
    end_of_test();
  end
endmodule

`default_nettype wire
